// ### scf_pkg.sv
// Shared constants and types for the framed command engine
// Behaviour
// RULE1: Identity is family, 48-bit serial, CRC-8.
// RULE2: Identity CRC-8 uses x^8+x^5+x^4+1.
// RULE3: Serial reads zero until a command executes; here loaded on any release byte AAh.
// RULE4: Commands accepted only after reset and ROM select.
// RULE5: Every exchange opens with start code 66h.
// RULE6: Decode 96h write, 44h read, AAh status.
// RULE7: Decode C3h protect, A5h signature, C9h decrement.
// RULE8: Decode 33h disable, D2h random, CBh public key.
// RULE9: Decode 59h key verify, 89h signed write.
// RULE10: Length byte follows start; command byte next.
// RULE11: Device returns inverted CRC-16 of request.
// RULE12: Execution starts only on release byte AAh.
// RULE13: Master holds strong pullup 15ms after release.
// RULE14: Dummy byte, then length, result, data, CRC.
// RULE15: Unsupported command answers length 00h, CRC FFFFh.
// RULE16: Disabled device answers one byte 88h.
// RULE17: Response CRC excludes dummy, sent inverted.
// RULE18: CRC-16 x^16+x^15+x^2+1, low byte first.
// RULE19: Bad CRC or release abandons until reset.
package scf_pkg;
	localparam logic [7:0] START_CODE   = 8'h66;
	localparam logic [7:0] RELEASE_CODE = 8'haa;
	localparam logic [7:0] ERR_DISABLED = 8'h88;
	localparam logic [7:0] DUMMY_BYTE   = 8'hff;
	localparam logic [7:0] OP_WRITE     = 8'h96;
	localparam logic [7:0] OP_READ      = 8'h44;
	localparam logic [7:0] OP_STATUS    = 8'haa;
	localparam logic [7:0] OP_PROTECT   = 8'hc3;
	localparam logic [7:0] OP_SIGN      = 8'ha5;
	localparam logic [7:0] OP_DECR      = 8'hc9;
	localparam logic [7:0] OP_DISABLE   = 8'h33;
	localparam logic [7:0] OP_RANDOM    = 8'hd2;
	localparam logic [7:0] OP_PUBKEY    = 8'hcb;
	localparam logic [7:0] OP_KEYCHK    = 8'h59;
	localparam logic [7:0] OP_SIGWRITE  = 8'h89;
	// Reflected forms of the two polynomials
	localparam logic [7:0]  CRC8_POLY   = 8'h8c;
	localparam logic [15:0] CRC16_POLY  = 16'ha001;
	localparam int          CLK_HZ      = 25000000;
	localparam int          SPU_MS      = 15;
	localparam int          SPU_CYCLES  = (CLK_HZ / 1000) * SPU_MS;

	typedef enum logic [3:0] {
		CMD_NONE, CMD_WRITE, CMD_READ, CMD_STATUS, CMD_PROTECT, CMD_SIGN,
		CMD_DECR, CMD_DISABLE, CMD_RANDOM, CMD_PUBKEY, CMD_KEYCHK, CMD_SIGWRITE
	} scf_cmd_t;

	function automatic logic [15:0] scf_crc16(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
		return r;
	endfunction

	function automatic logic [7:0] scf_crc8(input logic [55:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 56; i++)
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC8_POLY) : (r >> 1);
		return r;
	endfunction
endpackage

// ### scf_link_if.sv
// Byte-level link between the bus master and the device
`timescale 1ns/10ps
interface scf_link_if;
	logic       bus_rst;
	logic       rom_ok;
	logic       h2d_stb;
	logic [7:0] h2d_byte;
	logic       rd_stb;
	logic [7:0] d2h_byte;
	logic       busy;
	logic       spu;
	modport dev  (input bus_rst, rom_ok, h2d_stb, h2d_byte, rd_stb, spu,
	              output d2h_byte, busy);
	modport host (output bus_rst, rom_ok, h2d_stb, h2d_byte, rd_stb, spu,
	              input d2h_byte, busy);
endinterface

// ### scf_device.sv
// Device end: identity number, command decode and command framing
`timescale 1ns/10ps
module scf_device
	import scf_pkg::*;
#(
	parameter logic [7:0] FAMILY = 8'h5a  // Arbitrary value
)(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Link
	scf_link_if.dev         link,
	// Identity
	input  wire logic [47:0] serial_in,
	output logic      [63:0] rom_id,
	// Device state
	input  wire logic       disabled,
	// Command out
	output logic            exec,
	output scf_cmd_t        cmd_kind,
	output logic      [7:0] cmd_code,
	output logic            par_stb,
	output logic      [7:0] par_byte,
	output logic            abort,
	// Result in
	input  wire logic       done,
	input  wire logic [7:0] res_byte,
	input  wire logic [7:0] res_dlen,
	output logic            dat_rd,
	input  wire logic [7:0] dat_byte
);
	typedef enum logic [3:0] {
		S_ROM, S_START, S_LEN, S_CMD, S_PARAM, S_CRCL, S_CRCH, S_REL,
		S_RUN, S_DUMMY, S_RLEN, S_RBYTE, S_RDATA, S_RCL, S_RCH, S_DEAD
	} scf_dst_t;

	scf_dst_t    state;
	logic [7:0]  cnt;
	logic [15:0] crc;
	logic [47:0] serial;
	logic [7:0]  res_len;
	logic [7:0]  res_b;
	logic [7:0]  tx;
	logic [15:0] crc_wr;
	logic [15:0] crc_rd;
	scf_cmd_t    kind_nx;

	function automatic scf_cmd_t decode(input logic [7:0] c);
		case (c)
			OP_WRITE:    return CMD_WRITE;     // [RULE6]
			OP_READ:     return CMD_READ;      // [RULE6]
			OP_STATUS:   return CMD_STATUS;    // [RULE6]
			OP_PROTECT:  return CMD_PROTECT;   // [RULE7]
			OP_SIGN:     return CMD_SIGN;      // [RULE7]
			OP_DECR:     return CMD_DECR;      // [RULE7]
			OP_DISABLE:  return CMD_DISABLE;   // [RULE8]
			OP_RANDOM:   return CMD_RANDOM;    // [RULE8]
			OP_PUBKEY:   return CMD_PUBKEY;    // [RULE8]
			OP_KEYCHK:   return CMD_KEYCHK;    // [RULE9]
			OP_SIGWRITE: return CMD_SIGWRITE;  // [RULE9]
			default:     return CMD_NONE;
		endcase
	endfunction

	assign crc_wr   = scf_crc16(crc, link.h2d_byte);  // [RULE18]
	assign crc_rd   = scf_crc16(crc, tx);             // [RULE18]
	assign kind_nx  = decode(link.h2d_byte);
	assign link.d2h_byte = tx;
	assign link.busy     = (state == S_RUN);
	assign dat_rd = link.rd_stb && (state == S_RBYTE || state == S_RDATA) && cnt != 8'h00;

	// Identity number, family code in the low byte
	always_ff @(posedge clk)
	begin
		if (rst)
			rom_id <= {scf_crc8({48'h0, FAMILY}), 48'h0, FAMILY};  // [RULE3]
		else
			rom_id <= {scf_crc8({serial, FAMILY}), serial, FAMILY};  // [RULE1] [RULE2]
	end

	// Serial is loaded from serial_in at every release byte, executed or not
	always_ff @(posedge clk)
	begin
		if (rst)
			serial <= 48'h0;
		else if (state == S_REL && link.h2d_stb && link.h2d_byte == RELEASE_CODE)
			serial <= serial_in;  // [RULE3]
	end

	// Parameter bytes passed on one cycle late
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			par_stb  <= 1'b0;
			par_byte <= 8'h00;
		end
		else
		begin
			par_stb <= (state == S_PARAM) && link.h2d_stb;
			if (state == S_PARAM && link.h2d_stb)
				par_byte <= link.h2d_byte;
		end
	end

	// Frame sequencing
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state    <= S_ROM;
			cnt      <= 8'h00;
			crc      <= 16'h0;
			tx       <= DUMMY_BYTE;
			res_len  <= 8'h00;
			res_b    <= 8'h00;
			cmd_code <= 8'h00;
			cmd_kind <= CMD_NONE;
			exec     <= 1'b0;
			abort    <= 1'b0;
		end
		else
		begin
			exec  <= 1'b0;
			abort <= 1'b0;
			if (link.bus_rst)
			begin
				state <= S_ROM;
				tx    <= DUMMY_BYTE;
			end
			else
			begin
				case (state)
					S_ROM:
						if (link.rom_ok)
							state <= S_START;  // [RULE4]
					S_START:
						if (link.h2d_stb)
						begin
							crc   <= scf_crc16(16'h0, link.h2d_byte);
							state <= (link.h2d_byte == START_CODE) ? S_LEN : S_DEAD;  // [RULE5]
						end
					S_LEN:
						if (link.h2d_stb)
						begin
							crc   <= crc_wr;
							cnt   <= link.h2d_byte;  // [RULE10]
							state <= S_CMD;
						end
					S_CMD:
						if (link.h2d_stb)
						begin
							crc      <= crc_wr;
							cmd_code <= link.h2d_byte;  // [RULE10]
							cmd_kind <= kind_nx;
							if (cnt <= 8'h01)
							begin
								cnt   <= 8'h00;
								tx    <= ~crc_wr[7:0];  // [RULE11]
								state <= S_CRCL;
							end
							else
							begin
								cnt   <= cnt - 8'h01;
								state <= S_PARAM;
							end
						end
					S_PARAM:
						if (link.h2d_stb)
						begin
							crc <= crc_wr;
							cnt <= cnt - 8'h01;
							if (cnt == 8'h01)
							begin
								tx    <= ~crc_wr[7:0];  // [RULE11]
								state <= S_CRCL;
							end
						end
					S_CRCL:
						if (link.rd_stb)
						begin
							tx    <= ~crc[15:8];  // [RULE11] [RULE18]
							state <= S_CRCH;
						end
					S_CRCH:
						if (link.rd_stb)
						begin
							tx    <= DUMMY_BYTE;
							state <= S_REL;
						end
					S_REL:
						if (link.h2d_stb)
						begin
							crc <= 16'h0;
							if (link.h2d_byte != RELEASE_CODE)
							begin
								abort <= 1'b1;
								state <= S_DEAD;  // [RULE19]
							end
							else if (disabled)
							begin
								res_len <= 8'h01;
								res_b   <= ERR_DISABLED;  // [RULE16]
								cnt     <= 8'h00;
								state   <= S_DUMMY;
							end
							else if (cmd_kind == CMD_NONE)
							begin
								res_len <= 8'h00;  // [RULE15]
								state   <= S_DUMMY;
							end
							else
							begin
								exec  <= 1'b1;  // [RULE12]
								state <= S_RUN;
							end
						end
					S_RUN:
						if (done)
						begin
							res_b   <= res_byte;
							res_len <= res_dlen + 8'h01;
							cnt     <= res_dlen;
							state   <= S_DUMMY;
						end
					S_DUMMY:
						if (link.rd_stb)
						begin
							tx    <= res_len;  // [RULE14]
							state <= S_RLEN;
						end
					S_RLEN:
						if (link.rd_stb)
						begin
							crc <= crc_rd;  // [RULE17]
							if (res_len == 8'h00)
							begin
								tx    <= ~crc_rd[7:0];
								state <= S_RCL;
							end
							else
							begin
								tx    <= res_b;
								state <= S_RBYTE;
							end
						end
					S_RBYTE, S_RDATA:
						if (link.rd_stb)
						begin
							crc <= crc_rd;  // [RULE17]
							if (cnt == 8'h00)
							begin
								tx    <= ~crc_rd[7:0];
								state <= S_RCL;
							end
							else
							begin
								tx    <= dat_byte;  // [RULE14]
								cnt   <= cnt - 8'h01;
								state <= S_RDATA;
							end
						end
					S_RCL:
						if (link.rd_stb)
						begin
							tx    <= ~crc[15:8];  // [RULE17]
							state <= S_RCH;
						end
					S_RCH:
						if (link.rd_stb)
						begin
							tx    <= DUMMY_BYTE;
							state <= S_DEAD;
						end
					S_DEAD:
						state <= S_DEAD;
					default:
						state <= S_DEAD;
				endcase
			end
		end
	end
endmodule

// ### scf_host.sv
// Master end: issues one framed command and collects its result
`timescale 1ns/10ps
module scf_host
	import scf_pkg::*;
#(
	parameter int SPU_WAIT = SPU_CYCLES
)(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Link
	scf_link_if.host        link,
	// Command in
	input  wire logic       go,
	input  wire logic [7:0] len,
	output logic            tx_rd,
	input  wire logic [7:0] tx_byte,
	// Result out
	output logic            res_stb,
	output logic      [7:0] res_byte,
	output logic            fin,
	output logic            ok,
	output logic            crc_err
);
	typedef enum logic [3:0] {
		H_IDLE, H_RST, H_ROM, H_START, H_LEN, H_BODY, H_CRCL, H_CRCH,
		H_REL, H_SPU, H_WAIT, H_DUMMY, H_RLEN, H_RBODY, H_RCL, H_RCH
	} scf_hst_t;

	// Refused at elaboration: the pullup timer needs one cycle at least
	if (SPU_WAIT < 1)
	begin : g_spu_check
		$error("SPU_WAIT must be at least one cycle");
	end

	scf_hst_t    state;
	logic [7:0]  cnt;
	logic [15:0] crc;
	logic [7:0]  lo;
	logic [31:0] tmr;
	logic        cap;

	assign tx_rd = (state == H_BODY);
	// Read data is valid while our strobe stands
	assign cap = link.rd_stb;

	always_ff @(posedge clk)
	begin
		if (rst || go)
			crc <= 16'h0;
		else if (link.h2d_stb && state != H_SPU)
			crc <= scf_crc16(crc, link.h2d_byte);  // [RULE18]
		else if (cap && (state == H_RLEN || state == H_RBODY))
			crc <= scf_crc16(crc, link.d2h_byte);  // [RULE17]
		else if (cap && state == H_DUMMY)
			crc <= 16'h0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= H_IDLE;
			cnt   <= 8'h00;
			lo    <= 8'h00;
			tmr   <= 32'h0;
			link.bus_rst  <= 1'b0;
			link.rom_ok   <= 1'b0;
			link.h2d_stb  <= 1'b0;
			link.h2d_byte <= 8'h00;
			link.rd_stb   <= 1'b0;
			link.spu      <= 1'b0;
			res_stb  <= 1'b0;
			res_byte <= 8'h00;
			fin      <= 1'b0;
			ok       <= 1'b0;
			crc_err  <= 1'b0;
		end
		else
		begin
			link.bus_rst <= 1'b0;
			link.rom_ok  <= 1'b0;
			link.h2d_stb <= 1'b0;
			link.rd_stb  <= 1'b0;
			res_stb      <= 1'b0;
			fin          <= 1'b0;
			if ((state == H_CRCL || state == H_CRCH || state == H_DUMMY ||
			     state == H_RLEN || state == H_RBODY || state == H_RCL ||
			     state == H_RCH) && !cap)
				link.rd_stb <= 1'b1;
			case (state)
				H_IDLE:
					if (go)
					begin
						cnt   <= len;
						state <= H_RST;
					end
				H_RST:
				begin
					link.bus_rst <= 1'b1;
					state        <= H_ROM;
				end
				H_ROM:
				begin
					link.rom_ok <= 1'b1;  // [RULE4]
					state       <= H_START;
				end
				H_START:
				begin
					link.h2d_stb  <= 1'b1;
					link.h2d_byte <= START_CODE;  // [RULE5]
					state         <= H_LEN;
				end
				H_LEN:
				begin
					link.h2d_stb  <= 1'b1;
					link.h2d_byte <= cnt;  // [RULE10]
					state         <= (cnt == 8'h00) ? H_CRCL : H_BODY;
				end
				H_BODY:
				begin
					link.h2d_stb  <= 1'b1;
					link.h2d_byte <= tx_byte;
					cnt           <= cnt - 8'h01;
					if (cnt == 8'h01)
						state <= H_CRCL;
				end
				H_CRCL:
					if (cap)
					begin
						lo    <= link.d2h_byte;
						state <= H_CRCH;
					end
				H_CRCH:
					if (cap)
					begin
						if ({link.d2h_byte, lo} == ~crc)
							state <= H_REL;  // [RULE12]
						else
						begin
							crc_err <= 1'b1;
							ok      <= 1'b0;
							fin     <= 1'b1;
							state   <= H_IDLE;
						end
					end
				H_REL:
				begin
					link.h2d_stb  <= 1'b1;
					link.h2d_byte <= RELEASE_CODE;  // [RULE12]
					tmr           <= 32'h0;
					state         <= H_SPU;
				end
				H_SPU:
				begin
					link.spu <= 1'b1;  // [RULE13]
					tmr      <= tmr + 32'h1;
					if (tmr >= 32'(SPU_WAIT - 1))
						state <= H_WAIT;
				end
				// Stronger supply stays on until the device is idle too
				H_WAIT:
					if (!link.busy)
					begin
						link.spu <= 1'b0;
						state    <= H_DUMMY;
					end
				H_DUMMY:
					if (cap)
						state <= H_RLEN;  // [RULE14]
				H_RLEN:
					if (cap)
					begin
						cnt   <= link.d2h_byte;
						state <= (link.d2h_byte == 8'h00) ? H_RCL : H_RBODY;
					end
				H_RBODY:
					if (cap)
					begin
						res_stb  <= 1'b1;
						res_byte <= link.d2h_byte;
						cnt      <= cnt - 8'h01;
						if (cnt == 8'h01)
							state <= H_RCL;
					end
				H_RCL:
					if (cap)
					begin
						lo    <= link.d2h_byte;
						state <= H_RCH;
					end
				H_RCH:
					if (cap)
					begin
						ok      <= ({link.d2h_byte, lo} == ~crc);  // [RULE17]
						crc_err <= ({link.d2h_byte, lo} != ~crc);
						fin     <= 1'b1;
						state   <= H_IDLE;
					end
				default:
					state <= H_IDLE;
			endcase
		end
	end
endmodule

// ### scf_props.sv
// Assertions on the link between host and device
`timescale 1ns/10ps
module scf_props
	import scf_pkg::*;
#(
	parameter int SPU_WAIT = SPU_CYCLES
)(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Link
	input wire logic       bus_rst,
	input wire logic       rom_ok,
	input wire logic       h2d_stb,
	input wire logic [7:0] h2d_byte,
	input wire logic       rd_stb,
	input wire logic [7:0] d2h_byte,
	input wire logic       busy,
	input wire logic       spu
);
	int   spu_cnt;
	logic wait_dummy;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Length of the current pullup hold
	always_ff @(posedge clk)
	begin
		if (rst || !spu)
			spu_cnt <= 0;
		else
			spu_cnt <= spu_cnt + 1;
	end

	// First read after the pullup must be the dummy
	always_ff @(posedge clk)
	begin
		if (rst || rd_stb)
			wait_dummy <= 1'b0;
		else if ($fell(spu))
			wait_dummy <= 1'b1;
	end

	a_reset_quiet: assert property ($fell(rst) |-> !h2d_stb && !rd_stb && !spu && !busy
		&& d2h_byte == DUMMY_BYTE) else $error("link not idle after reset");
	a_rom_after_reset: assert property (bus_rst |=> rom_ok)
		else $error("no ROM select after bus reset");
	a_start_code: assert property (rom_ok |=> h2d_stb && h2d_byte == START_CODE)
		else $error("frame does not open with start code");
	a_len_follows: assert property (rom_ok ##1 h2d_stb |=> h2d_stb)
		else $error("length byte does not follow start code");
	a_no_early_spu: assert property (h2d_stb |-> !spu)
		else $error("pullup held while a byte is sent");
	a_spu_hold_min: assert property ($fell(spu) |-> spu_cnt >= SPU_WAIT)
		else $error("pullup hold too short");
	a_release_first: assert property ($rose(spu) |->
		(h2d_stb && h2d_byte == RELEASE_CODE) ||
		($past(h2d_stb) && $past(h2d_byte) == RELEASE_CODE))
		else $error("pullup without release");
	a_dummy_soon: assert property ($fell(spu) |-> ##[0:8] rd_stb)
		else $error("dummy byte not read");
	a_dummy_value: assert property (rd_stb && (wait_dummy || $fell(spu))
		|-> d2h_byte == DUMMY_BYTE) else $error("dummy byte value wrong");
	a_busy_silent: assert property (busy |-> !rd_stb && !h2d_stb)
		else $error("link traffic while device busy");

	c_release: cover property ($rose(spu));
	c_disabled: cover property (rd_stb && d2h_byte == ERR_DISABLED);
	c_frame: cover property (rom_ok ##1 h2d_stb);
endmodule

// ### scf_tb_top.sv
// Testbench: host and device joined end to end over the link
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module scf_tb_top
	import scf_pkg::*;
;
	localparam logic [7:0] FAM = 8'h5a;  // Arbitrary value
	localparam logic [7:0] OPS [11] = '{OP_WRITE, OP_READ, OP_STATUS, OP_PROTECT, OP_SIGN,
		OP_DECR, OP_DISABLE, OP_RANDOM, OP_PUBKEY, OP_KEYCHK, OP_SIGWRITE};
	logic        clk, rst, go, done, disabled;
	logic [7:0]  len, tx_byte, d_res, d_dlen, dat_byte, xcode;
	logic [47:0] serial_in;
	logic [63:0] rom_id;
	logic        tx_rd, res_stb, fin, ok, crc_err, exec, par_stb, abort, dat_rd;
	logic [7:0]  res_byte, cmd_code, par_byte;
	scf_cmd_t    cmd_kind, xkind;
	int          fails, n_checks, n_exec;
	logic [7:0]  txq[$], expq[$], parq[$], wq[$], dat[$];

	scf_link_if link();
	scf_host #(.SPU_WAIT(20)) i_scf_host (.clk(clk), .rst(rst), .link(link), .go(go),
		.len(len), .tx_rd(tx_rd), .tx_byte(tx_byte), .res_stb(res_stb), .res_byte(res_byte),
		.fin(fin), .ok(ok), .crc_err(crc_err));
	scf_device #(.FAMILY(FAM)) i_scf_device (.clk(clk), .rst(rst), .link(link),
		.serial_in(serial_in), .rom_id(rom_id), .disabled(disabled), .exec(exec),
		.cmd_kind(cmd_kind), .cmd_code(cmd_code), .par_stb(par_stb), .par_byte(par_byte),
		.abort(abort), .done(done), .res_byte(d_res), .res_dlen(d_dlen), .dat_rd(dat_rd),
		.dat_byte(dat_byte));
	scf_props #(.SPU_WAIT(20)) i_scf_props (.clk(clk), .rst(rst), .bus_rst(link.bus_rst),
		.rom_ok(link.rom_ok), .h2d_stb(link.h2d_stb), .h2d_byte(link.h2d_byte),
		.rd_stb(link.rd_stb), .d2h_byte(link.d2h_byte), .busy(link.busy), .spu(link.spu));

	assign tx_byte = txq.size() ? txq[0] : 8'h00;
	assign dat_byte = dat.size() ? dat[0] : 8'hff;

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'h0000;
		foreach (b[i])
			for (int j = 0; j < 8; j++)
				c = (c[0] ^ b[i][j]) ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
		return c;
	endfunction

	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC8_POLY) : (c >> 1);
		return c;
	endfunction

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Consumers of the strobed outputs
	always @(posedge clk)
	begin
		// Note popped once, so a mismatch print cannot pop again
		logic [7:0] e;
		if (res_stb === 1'b1)
		begin
			e = expq.pop_front();
			`CHK(res_byte, e)
		end
		if (par_stb === 1'b1)
		begin
			e = parq.pop_front();
			`CHK(par_byte, e)
		end
		if (exec === 1'b1)
		begin
			n_exec++;
			`CHK(cmd_code, xcode)
			`CHK(cmd_kind, xkind)
		end
		// Abort is unknown until the first reset edge has landed
		if (rst === 1'b0)
			`CHK(abort, 1'b0)
		if (link.rd_stb === 1'b1)
			wq.push_back(link.d2h_byte);
		if (tx_rd === 1'b1)
			#1 void'(txq.pop_front());
	end

	always @(posedge clk)
		if (dat_rd === 1'b1)
			#1 void'(dat.pop_front());

	// Command execution stand-in: answers a few cycles into busy
	initial
		forever
		begin
			@(posedge clk);
			if (link.busy === 1'b1)
			begin
				repeat (3) @(posedge clk);
				#1 done = 1'b1;
				@(posedge clk);
				#1 done = 1'b0;
				while (link.busy === 1'b1)
					@(posedge clk);
			end
		end

	task automatic run(input logic [7:0] code, input scf_cmd_t kind, input int np, input logic dis);
		logic [7:0]  req[$];
		logic [7:0]  rsp[$];
		logic [7:0]  ew[$];
		logic [15:0] c;
		int          k;
		req = {START_CODE, 8'(np + 1), code};
		txq = {code};
		xcode = code;
		xkind = kind;
		n_exec = 0;
		for (k = 0; k < np; k++)
		begin
			req.push_back(8'($urandom));
			txq.push_back(req[$]);
			parq.push_back(req[$]);
		end
		@(posedge clk);
		#1 d_res = 8'($urandom);
		d_dlen = 8'($urandom_range(0, 3));
		disabled = dis;
		dat = {};
		for (k = 0; k < d_dlen; k++)
			dat.push_back(8'($urandom));
		if (dis)
			rsp = {8'h01, ERR_DISABLED};
		else if (kind == CMD_NONE)
			rsp = {8'h00};
		else
			rsp = {8'(d_dlen + 1), d_res, dat};
		expq = rsp[1:$];
		c = crc16(req);
		ew = {~c[7:0], ~c[15:8], DUMMY_BYTE, rsp};
		c = crc16(rsp);
		ew = {ew, ~c[7:0], ~c[15:8]};
		go = 1'b1;
		len = 8'(np + 1);
		@(posedge clk);
		#1 go = 1'b0;
		k = 0;
		while (fin !== 1'b1 && k < 3000)
		begin
			@(negedge clk);
			k++;
		end
		`CHK(fin, 1'b1)
		`CHK(ok, 1'b1)
		`CHK(crc_err, 1'b0)
		`CHK(wq.size(), ew.size())
		foreach (ew[i])
			`CHK(wq[i], ew[i])
		`CHK(n_exec, int'(kind != CMD_NONE && !dis))
		wq = {};
		$display("test %h done", code);
	endtask

	initial
	begin
		#800000;
		fails++;
		final_report();
	end

	initial
	begin
		go = 1'b0;
		len = 8'h00;
		done = 1'b0;
		disabled = 1'b0;
		d_res = 8'h00;
		d_dlen = 8'h00;
		serial_in = 48'h0;
		rst = 1'b1;
		void'($urandom(32'hba54));
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		`CHK(rom_id, {crc8({48'h0, FAM}), 48'h0, FAM})
		serial_in = 48'({$urandom, $urandom});
		run(OP_STATUS, CMD_STATUS, 1, 1'b0);
		`CHK(rom_id, {crc8({serial_in, FAM}), serial_in, FAM})
		for (int i = 0; i < 11; i++)
			run(OPS[i], scf_cmd_t'(i + 1), $urandom_range(0, 4), 1'b0);
		run(8'h00, CMD_NONE, 0, 1'b0);
		run(OP_READ, CMD_READ, 0, 1'b1);
		final_report();
	end
endmodule
